// ### rtl/imbc_consts.vh
`ifndef IMBC_CONSTS_VH
`define IMBC_CONSTS_VH

// Serial command word layout
`define IMBC_WRITE_BIT          15
`define IMBC_ADDR_MSB           14
`define IMBC_ADDR_LSB           8
`define IMBC_BURST_CMD          16'h6800

// Byte addresses of the user register space
`define IMBC_DATA_FIRST         7'h02
`define IMBC_DATA_LAST          7'h3B
`define IMBC_BACKUP_FIRST       7'h40
`define IMBC_BACKUP_LAST        7'h5D
`define IMBC_FILTER_LO          7'h5C
`define IMBC_FILTER_HI          7'h5D
`define IMBC_MISC_CONTROL_LO    7'h60
`define IMBC_MISC_CONTROL_WORD  6'h30
`define IMBC_DECIMATION_LO      7'h64
`define IMBC_DECIMATION_HI      7'h65
`define IMBC_DECIMATION_WORD    6'h32
`define IMBC_GLOBAL_COMMAND_LO  7'h70

// Field positions
`define IMBC_WIDE_BURST_BIT     0
`define IMBC_BURST_SEL_BIT      1
`define IMBC_SCALED_SYNC_BIT    2
`define IMBC_SAVE_BIT           3
`define IMBC_FILTER_LEN_MSB     2

// Output word indexes (byte address divided by two)
`define IMBC_IDX_DIAG           5'h01
`define IMBC_IDX_RATE_BASE      5'h02
`define IMBC_IDX_TEMP           5'h0E
`define IMBC_IDX_STAMP          5'h0F
`define IMBC_IDX_COUNTER        5'h11
`define IMBC_IDX_STEP_BASE      5'h12

// Frame lengths in words, checksum included, and data words per frame
`define IMBC_WIDE_LEN           5'h10
`define IMBC_NARROW_LEN         5'h0A
`define IMBC_WIDE_DATA          5'h0C
`define IMBC_NARROW_DATA        5'h06

`endif

// ### rtl/imbc_fifo.v
`timescale 1ns/1ps

module imbc_fifo
#(
	parameter WIDTH = 22,
	parameter DEPTH = 8,
	parameter AW    = 3
)
(
	input  wire             i_clk,
	input  wire             i_reset,
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	localparam [AW:0] FULL = DEPTH;
	localparam [AW:0] ONE  = 1;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr_reg;
	reg [AW-1:0]    rptr_reg;
	reg [AW:0]      count_reg;
	reg [AW:0]      count_next;
	reg             in_ready_reg;
	reg             out_valid_reg;
	reg [WIDTH-1:0] out_data_reg;

	wire push = i_in_valid & in_ready_reg;
	wire load = (count_reg != {(AW+1){1'b0}}) & (~out_valid_reg | i_out_ready);

	assign o_in_ready  = in_ready_reg;
	assign o_out_valid = out_valid_reg;
	assign o_out_data  = out_data_reg;

	always @*
	begin
		count_next = count_reg;
		if (push & ~load)
			count_next = count_reg + ONE;
		else if (~push & load)
			count_next = count_reg - ONE;
	end

	always @(posedge i_clk)
	begin
		if (push)
			mem[wptr_reg] <= i_in_data;
		if (load)
			out_data_reg <= mem[rptr_reg];
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			wptr_reg      <= {AW{1'b0}};
			rptr_reg      <= {AW{1'b0}};
			count_reg     <= {(AW+1){1'b0}};
			in_ready_reg  <= 1'b0;
			out_valid_reg <= 1'b0;
		end
		else
		begin
			count_reg    <= count_next;
			in_ready_reg <= (count_next != FULL);
			if (push)
				wptr_reg <= wptr_reg + ONE[AW-1:0];
			if (load)
			begin
				rptr_reg      <= rptr_reg + ONE[AW-1:0];
				out_valid_reg <= 1'b1;
			end
			else if (i_out_ready)
				out_valid_reg <= 1'b0;
		end
	end
endmodule

// ### rtl/imbc_port.v
`timescale 1ns/1ps
`include "imbc_consts.vh"

module imbc_port
#(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW    = 3
)
(
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_spi_sclk,
	input  wire        i_spi_cs_n,
	input  wire        i_spi_mosi,
	output reg         o_spi_miso,
	output reg         o_spi_miso_oe_n,
	input  wire        i_sample_valid,
	input  wire        i_sample_last,
	input  wire [4:0]  i_sample_index,
	input  wire [15:0] i_sample_data,
	output wire        o_sample_ready,
	output reg  [15:0] o_group_delay,
	output reg         o_burst_active
);
	reg [1:0]  sclk_sync_reg;
	reg [1:0]  cs_sync_reg;
	reg [1:0]  mosi_sync_reg;
	reg        sclk_prev_reg;
	reg [3:0]  bit_cnt_reg;
	reg [14:0] rx_shift_reg;
	reg [15:0] tx_shift_reg;
	reg [15:0] tx_word_reg;
	reg [4:0]  burst_pos_reg;
	reg [15:0] checksum_reg;
	reg        write_bank_reg;

	reg [15:0] image_mem [0:63];
	reg [7:0]  cfg_mem [0:127];
	reg [7:0]  nv_mem [0:127];

	reg [6:0]  rd_addr;
	reg [15:0] rd_value;
	reg [4:0]  frame_pos;
	reg [4:0]  frame_len;
	reg [4:0]  frame_idx;
	reg [15:0] frame_value;
	reg        frame_adds;
	reg [15:0] csum_base;
	reg [15:0] csum_next;
	reg [16:0] dec_plus_one;
	reg [15:0] group_delay_next;

	integer i;

	wire        cs_active  = ~cs_sync_reg[1];
	wire        sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg;
	wire        sclk_fall  = ~sclk_sync_reg[1] & sclk_prev_reg;
	wire [15:0] rx_word    = {rx_shift_reg, mosi_sync_reg[1]};
	wire        word_done  = cs_active & sclk_rise & (bit_cnt_reg == 4'hF);
	wire        read_bank  = ~write_bank_reg;
	wire [7:0]  misc_ctrl  = cfg_mem[`IMBC_MISC_CONTROL_LO];
	wire        wide_burst = misc_ctrl[`IMBC_WIDE_BURST_BIT];
	wire        burst_sel  = misc_ctrl[`IMBC_BURST_SEL_BIT];
	wire        stamp_mode = misc_ctrl[`IMBC_SCALED_SYNC_BIT];
	wire        is_burst   = ~o_burst_active & (rx_word == `IMBC_BURST_CMD);
	wire        burst_start = word_done & is_burst;
	wire        wr_en      = word_done & ~o_burst_active & rx_word[`IMBC_WRITE_BIT];
	wire [6:0]  wr_addr    = rx_word[`IMBC_ADDR_MSB:`IMBC_ADDR_LSB];
	wire [7:0]  wr_data    = rx_word[7:0];
	wire [15:0] filt_word  = {cfg_mem[`IMBC_FILTER_HI], cfg_mem[`IMBC_FILTER_LO]};
	wire [15:0] dec_word   = {cfg_mem[`IMBC_DECIMATION_HI], cfg_mem[`IMBC_DECIMATION_LO]};

	wire        fifo_valid;
	wire [21:0] fifo_data;
	wire        fifo_last  = fifo_data[21];
	wire [4:0]  fifo_index = fifo_data[20:16];
	wire        drain_rdy  = ~(fifo_last & (o_burst_active | burst_start));

	function is_backed;
		input [6:0] a;
		begin
			is_backed = ((a >= `IMBC_BACKUP_FIRST) && (a <= `IMBC_BACKUP_LAST))
				|| (a[6:1] == `IMBC_MISC_CONTROL_WORD)
				|| (a[6:1] == `IMBC_DECIMATION_WORD);
		end
	endfunction

	// Output data address range
	function is_output;
		input [6:0] a;
		begin
			is_output = (a >= `IMBC_DATA_FIRST) && (a <= `IMBC_DATA_LAST);
		end
	endfunction

	// Byte-wise checksum step
	function [15:0] byte_sum;
		input [15:0] base;
		input [15:0] w;
		begin
			byte_sum = base + {8'h00, w[15:8]} + {8'h00, w[7:0]};
		end
	endfunction

	// Frame length in words
	function [4:0] frame_length;
		input wide;
		begin
			frame_length = wide ? `IMBC_WIDE_LEN : `IMBC_NARROW_LEN;
		end
	endfunction

	function [4:0] frame_index;
		input       wide;
		input       sel;
		input       stamp;
		input [4:0] pos;
		reg   [4:0] base;
		reg   [4:0] tail;
		begin
			base = sel ? `IMBC_IDX_STEP_BASE : `IMBC_IDX_RATE_BASE;
			tail = wide ? `IMBC_WIDE_DATA : `IMBC_NARROW_DATA;
			if (pos == 5'h00)
				frame_index = `IMBC_IDX_DIAG;
			else if (pos <= tail)
				frame_index = wide ? (base + pos - 5'h01) : (base + {pos[3:0], 1'b0} - 5'h01);
			else if (pos == tail + 5'h01)
				frame_index = `IMBC_IDX_TEMP;
			else
				frame_index = stamp ? `IMBC_IDX_STAMP : `IMBC_IDX_COUNTER;
		end
	endfunction

	initial
	begin
		for (i = 0; i < 128; i = i + 1)
			nv_mem[i] = 8'h00;
	end

	imbc_fifo
	#(
		.WIDTH (22),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	)
	u_fifo
	(
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_in_valid  (i_sample_valid),
		.i_in_data   ({i_sample_last, i_sample_index, i_sample_data}),
		.o_in_ready  (o_sample_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (drain_rdy)
	);

	// Register read and burst frame word selection
	always @*
	begin
		rd_addr  = rx_word[`IMBC_ADDR_MSB:`IMBC_ADDR_LSB];
		rd_value = 16'h0000;
		if (is_output(rd_addr))
			rd_value = image_mem[{read_bank, rd_addr[5:1]}];
		else if (is_backed(rd_addr))
			rd_value = {cfg_mem[{rd_addr[6:1], 1'b1}], cfg_mem[{rd_addr[6:1], 1'b0}]};
		frame_pos   = o_burst_active ? burst_pos_reg : 5'h00;
		frame_len   = frame_length(wide_burst);
		frame_idx   = frame_index(wide_burst, burst_sel, stamp_mode, frame_pos);
		frame_value = 16'h0000;
		frame_adds  = 1'b0;
		if (frame_pos == frame_len - 5'h01)
			frame_value = checksum_reg;
		else if (frame_pos < frame_len - 5'h01)
		begin
			frame_value = image_mem[{read_bank, frame_idx}];
			frame_adds  = 1'b1;
		end
		csum_base = o_burst_active ? checksum_reg : 16'h0000;
		csum_next = byte_sum(csum_base, frame_value);
	end

	// Group delay added by the averaging and decimation filters
	always @*
	begin
		dec_plus_one     = {1'b0, dec_word} + 17'h0_0001;
		group_delay_next = 16'h0000;
		if (filt_word != 16'h0000)
			group_delay_next = {13'h0000, filt_word[`IMBC_FILTER_LEN_MSB:0]};
		if (dec_word != 16'h0000)
			group_delay_next = group_delay_next + dec_plus_one[16:1];
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
			o_group_delay <= 16'h0000;
		else
			o_group_delay <= group_delay_next;
	end

	// Two-flop synchronisers for the serial pins
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			sclk_sync_reg <= 2'b11;
			cs_sync_reg   <= 2'b11;
			mosi_sync_reg <= 2'b00;
			sclk_prev_reg <= 1'b1;
		end
		else
		begin
			sclk_sync_reg <= {sclk_sync_reg[0], i_spi_sclk};
			cs_sync_reg   <= {cs_sync_reg[0], i_spi_cs_n};
			mosi_sync_reg <= {mosi_sync_reg[0], i_spi_mosi};
			sclk_prev_reg <= sclk_sync_reg[1];
		end
	end

	// Serial link, command decode and burst sequencing
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			bit_cnt_reg     <= 4'h0;
			rx_shift_reg    <= 15'h0000;
			tx_shift_reg    <= 16'h0000;
			tx_word_reg     <= 16'h0000;
			burst_pos_reg   <= 5'h00;
			checksum_reg    <= 16'h0000;
			o_spi_miso      <= 1'b0;
			o_spi_miso_oe_n <= 1'b1;
			o_burst_active  <= 1'b0;
		end
		else
		begin
			o_spi_miso_oe_n <= cs_sync_reg[1];
			if (~cs_active)
			begin
				bit_cnt_reg    <= 4'h0;
				burst_pos_reg  <= 5'h00;
				o_burst_active <= 1'b0;
				tx_word_reg    <= 16'h0000;
			end
			else
			begin
				if (sclk_fall)
				begin
					if (bit_cnt_reg == 4'h0)
					begin
						o_spi_miso   <= tx_word_reg[15];
						tx_shift_reg <= {tx_word_reg[14:0], 1'b0};
					end
					else
					begin
						o_spi_miso   <= tx_shift_reg[15];
						tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
					end
				end
				if (sclk_rise)
				begin
					bit_cnt_reg  <= bit_cnt_reg + 4'h1;
					rx_shift_reg <= {rx_shift_reg[13:0], mosi_sync_reg[1]};
				end
				if (word_done)
				begin
					if (o_burst_active | is_burst)
					begin
						o_burst_active <= 1'b1;
						tx_word_reg    <= frame_value;
						if (frame_adds)
							checksum_reg <= csum_next;
						if (frame_pos != frame_len)
							burst_pos_reg <= frame_pos + 5'h01;
					end
					else if (rx_word[`IMBC_WRITE_BIT])
						tx_word_reg <= 16'h0000;
					else
						tx_word_reg <= rd_value;
				end
			end
		end
	end

	// Working configuration copy and non-volatile store
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			for (i = 0; i < 128; i = i + 1)
				cfg_mem[i] <= is_backed(i[6:0]) ? nv_mem[i] : 8'h00;
		end
		else if (wr_en)
		begin
			if (wr_addr == `IMBC_GLOBAL_COMMAND_LO)
			begin
				if (wr_data[`IMBC_SAVE_BIT])
				begin
					for (i = 0; i < 128; i = i + 1)
						if (is_backed(i[6:0]))
							nv_mem[i] <= cfg_mem[i];
				end
			end
			else if (is_backed(wr_addr))
				cfg_mem[wr_addr] <= wr_data;
		end
	end

	// Double-buffered sample image; bank swap waits while a burst runs
	always @(posedge i_clk)
	begin
		if (fifo_valid & drain_rdy)
			image_mem[{write_bank_reg, fifo_index}] <= fifo_data[15:0];
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
			write_bank_reg <= 1'b0;
		else if (fifo_valid & drain_rdy & fifo_last)
			write_bank_reg <= ~write_bank_reg;
	end
endmodule

// ### verification/imbc_asserts.sv
`timescale 1ns/1ps
module imbc_asserts
(
	input wire        i_clk,
	input wire        i_reset,
	input wire        i_spi_sclk,
	input wire        i_spi_cs_n,
	input wire        i_spi_mosi,
	input wire        o_spi_miso,
	input wire        o_spi_miso_oe_n,
	input wire        i_sample_valid,
	input wire        i_sample_last,
	input wire [4:0]  i_sample_index,
	input wire [15:0] i_sample_data,
	input wire        o_sample_ready,
	input wire [15:0] o_group_delay,
	input wire        o_burst_active
);
	reg [3:0] hi_cnt;
	reg [5:0] cs_cnt;
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			hi_cnt <= 4'h0;
			cs_cnt <= 6'h00;
		end
		else
		begin
			hi_cnt <= !i_spi_sclk ? 4'h0 : (hi_cnt == 4'hF ? hi_cnt : hi_cnt + 4'h1);
			cs_cnt <= !i_spi_cs_n ? 6'h00 : (cs_cnt == 6'h3F ? cs_cnt : cs_cnt + 6'h01);
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	oe_follow_a: assert property (o_spi_miso_oe_n == $past(i_spi_cs_n, 3))
		else $error("miso enable does not follow select");
	miso_hold_a: assert property ((hi_cnt >= 4'h6 && !o_spi_miso_oe_n && $past(!o_spi_miso_oe_n))
		|-> $stable(o_spi_miso)) else $error("miso moved without falling serial clock");
	delay_quiet_a: assert property (cs_cnt == 6'h3F |-> $stable(o_group_delay))
		else $error("group delay moved without access");
	delay_range_a: assert property (o_group_delay <= 16'h8007)
		else $error("group delay out of range");
	burst_drop_a: assert property ($rose(i_spi_cs_n) |-> ##[1:5] !o_burst_active)
		else $error("burst not ended by deselect");
	burst_sel_a: assert property (o_burst_active |-> cs_cnt < 6'h05)
		else $error("burst active while deselected");
	ready_drop_a: assert property ($fell(o_sample_ready) |-> $past(i_sample_valid))
		else $error("ready fell without a write");
	reset_state_a: assert property ($past(i_reset) |-> o_spi_miso_oe_n && !o_burst_active
		&& !o_spi_miso) else $error("outputs wrong after reset");
	cover property (o_burst_active);
	cover property ($fell(o_sample_ready));
	cover property (o_group_delay == 16'h0006);
endmodule

bind imbc_port imbc_asserts imbc_asserts_i (.i_clk(i_clk), .i_reset(i_reset),
	.i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi),
	.o_spi_miso(o_spi_miso), .o_spi_miso_oe_n(o_spi_miso_oe_n),
	.i_sample_valid(i_sample_valid), .i_sample_last(i_sample_last),
	.i_sample_index(i_sample_index), .i_sample_data(i_sample_data),
	.o_sample_ready(o_sample_ready), .o_group_delay(o_group_delay),
	.o_burst_active(o_burst_active));

// ### verification/imbc_host.sv
`timescale 1ns/1ps
module imbc_host
(
	input  wire i_clk,
	input  wire i_miso,
	input  wire i_miso_oe_n,
	output reg  o_sclk,
	output reg  o_cs_n,
	output reg  o_mosi
);
	initial
	begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_mosi = 1'b1;
	end
	task half;
		repeat (4) @(negedge i_clk);
	endtask
	task open;
	begin
		half;
		o_cs_n = 1'b0;
		half;
	end
	endtask
	task close;
	begin
		half;
		o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
		half;
		half;
	end
	endtask
	task xfer(input [15:0] tx, output [15:0] rx);
		integer b;
	begin
		for (b = 15; b >= 0; b = b - 1)
		begin
			o_sclk = 1'b0;
			o_mosi = tx[b];
			half;
			o_sclk = 1'b1;
			rx[b] = i_miso_oe_n ? ~o_mosi : i_miso;
			half;
		end
	end
	endtask
endmodule

// ### verification/imbc_port_test.sv
`timescale 1ns/1ps
module imbc_port_test;
	reg         i_clk = 1'b0;
	reg         i_reset = 1'b1;
	reg         sv = 1'b0;
	reg         sl = 1'b0;
	reg  [4:0]  si = 5'h00;
	reg  [15:0] sd = 16'h0000;
	reg  [15:0] rx;
	reg  [15:0] sum;
	reg         full = 1'b0;
	integer     fails = 0;
	integer     checks = 0;
	integer     cyc = 0;
	wire        sclk, cs_n, mosi, miso, oe_n, rdy, busy;
	wire [15:0] gd;

	imbc_port imbc_port_i (.i_clk(i_clk), .i_reset(i_reset), .i_spi_sclk(sclk),
		.i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n),
		.i_sample_valid(sv), .i_sample_last(sl), .i_sample_index(si), .i_sample_data(sd),
		.o_sample_ready(rdy), .o_group_delay(gd), .o_burst_active(busy));
	imbc_host imbc_host_i (.i_clk(i_clk), .i_miso(miso), .i_miso_oe_n(oe_n), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_mosi(mosi));

	always #10 i_clk = ~i_clk;
	always @(negedge i_clk)
		if (sv && !rdy)
			full = 1'b1;
	always @(posedge i_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			fails = fails + 1;
			$display("ERROR %0t: timeout", $time);
			summarize;
		end
	end

	function [15:0] val(input [3:0] s, input [4:0] ix);
		val = {s, 3'b000, ix, ix[3:0]};
	endfunction
	task summarize;
	begin
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [6:0] a, input [7:0] d);
	begin
		imbc_host_i.open;
		imbc_host_i.xfer({1'b1, a, d}, rx);
		imbc_host_i.close;
	end
	endtask
	task rd(input [6:0] a, input [15:0] exp);
	begin
		imbc_host_i.open;
		imbc_host_i.xfer({1'b0, a, 8'h00}, rx);
		imbc_host_i.xfer(16'h0000, rx);
		imbc_host_i.close;
		chk(rx, exp);
	end
	endtask
	task push(input [4:0] ix, input [15:0] d, input l);
	begin
		@(negedge i_clk);
		sv = 1'b1;
		si = ix;
		sd = d;
		sl = l;
		while (!rdy)
			@(negedge i_clk);
		@(posedge i_clk);
	end
	endtask
	task load(input [3:0] s);
		integer k;
	begin
		for (k = 1; k < 30; k = k + 1)
			if (k != 16)
				push(k[4:0], val(s, k[4:0]), k == 29);
		@(negedge i_clk);
		sv = 1'b0;
	end
	endtask
	task burst(input [3:0] s, input [4:0] base, input [4:0] tail, input wd);
		integer k;
		integer n;
		reg [4:0] ix;
		reg [15:0] w;
	begin
		sum = 16'h0000;
		n = wd ? 12 : 6;
		imbc_host_i.open;
		imbc_host_i.xfer(16'h6800, rx);
		for (k = 0; k < n + 3; k = k + 1)
		begin
			ix = k == 0 ? 5'h01 : k <= n ? base + (wd ? k[4:0] : {k[3:0], 1'b0}) - 5'h01
				: k == n + 1 ? 5'h0E : tail;
			w = val(s, ix);
			imbc_host_i.xfer(16'h0000, rx);
			chk(rx, w);
			sum = sum + {8'h00, w[15:8]} + {8'h00, w[7:0]};
		end
		imbc_host_i.xfer(16'h0000, rx);
		chk(rx, sum);
		imbc_host_i.close;
	end
	endtask

	initial
	begin
		repeat (3) @(negedge i_clk);
		i_reset = 1'b0;
		repeat (8) @(negedge i_clk);
		chk(gd, 16'h0000);
		imbc_host_i.open;
		imbc_host_i.xfer(16'hDC04, rx);
		imbc_host_i.xfer(16'hDD00, rx);
		chk(rx, 16'h0000);
		imbc_host_i.xfer(16'h5C00, rx);
		chk(rx, 16'h0000);
		imbc_host_i.xfer(16'h0000, rx);
		chk(rx, 16'h0004);
		imbc_host_i.close;
		chk(gd, 16'h0004);
		wr(7'h64, 8'h03);
		wr(7'h65, 8'h00);
		chk(gd, 16'h0006);
		load(4'h3);
		burst(4'h3, 5'h02, 5'h11, 1'b0);
		wr(7'h60, 8'h01);
		wr(7'h61, 8'h00);
		burst(4'h3, 5'h02, 5'h11, 1'b1);
		wr(7'h60, 8'h03);
		fork
			burst(4'h3, 5'h12, 5'h11, 1'b1);
			begin
				wait (busy);
				load(4'h5);
				load(4'h6);
			end
		join
		chk({15'h0000, full}, 16'h0001);
		wr(7'h60, 8'h07);
		burst(4'h6, 5'h12, 5'h0F, 1'b1);
		wr(7'h70, 8'h08);
		wr(7'h5C, 8'h01);
		chk(gd, 16'h0003);
		@(negedge i_clk);
		i_reset = 1'b1;
		repeat (3) @(negedge i_clk);
		i_reset = 1'b0;
		repeat (80) @(negedge i_clk);
		chk(gd, 16'h0006);
		rd(7'h5C, 16'h0004);
		rd(7'h61, 16'h0007);
		rd(7'h70, 16'h0000);
		rd(7'h00, 16'h0000);
		summarize;
	end
endmodule
